// [pkg/fault_irq_defs.svh]
// Register offsets, reset values, writable masks and bit positions of the fault latch block.
`ifndef FAULT_IRQ_DEFS_SVH
`define FAULT_IRQ_DEFS_SVH

`define ADDR_CLOCK_BOOST_MASK   8'h2F
`define ADDR_OV_MASK            8'h32
`define ADDR_MON_MASK           8'h33
`define ADDR_CB_LATCH           8'h34
`define ADDR_SUMMARY            8'h35
`define ADDR_CH1_LATCH          8'h36

`define RST_CB_MASK             8'hFF
`define RST_OV_MASK             8'h00
`define RST_MON_MASK            8'h30
`define RST_LATCH               8'h00
`define READ_UNMAPPED           8'h00

`define WMASK_CB                8'hF8
`define WMASK_OV                8'hC0
`define WMASK_MON               8'hFF

`define OV_POS_BIT              7
`define OV_NEG_BIT              6
`define MON_GPA_UP_BIT          7
`define MON_GPA_LOW_BIT         6
`define MON_VAD_UP_BIT          5
`define MON_VAD_DOWN_BIT        4
`define MON_BIAS_SC_BIT         3
`define MON_BIAS_OV_BIT         0
`define CB_FIELD_HI             7
`define CB_FIELD_LO             3
`define SUM_CH1_BIT             7
`define SUM_CH2_BIT             6
`define SUM_VBAT_BIT            3

`endif

// [pkg/fault_irq_pkg.sv]
// Types and helper functions shared by the fault latch block.
package fault_irq_pkg;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Field order matches bits 7 down to 3 of the clock and boost latch.
	typedef struct packed {
		logic clock_error;
		logic pll_lock;
		logic boost_over_temp;
		logic boost_over_current;
		logic auxiliary_boost_fault;
	} clock_boost_fault_t;

	// Field order matches bits 7 down to 0 of the channel 1 input latch.
	typedef struct packed {
		logic open_input;
		logic inputs_shorted;
		logic positive_input_gnd;
		logic negative_input_gnd;
		logic positive_input_bias;
		logic negative_input_bias;
		logic positive_input_battery;
		logic negative_input_battery;
	} ch1_fault_t;

	// Latched flags and masks that live in neighbouring register blocks.
	typedef struct packed {
		logic [1:0] ov_latched;
		logic [7:0] mon_latched;
		logic       ch2_latched_any;
		logic [7:0] summary_mask;
		logic [7:0] ch1_mask;
	} neighbour_t;

	function automatic logic [7:0] masked_pending(input logic [7:0] flags,
		input logic [7:0] mask);
		return flags & ~mask;
	endfunction : masked_pending

endpackage : fault_irq_pkg

// [rtl/fault_latch_bank.sv]
// Bank of sticky fault flags that a host read clears unless the fault is still present.
module fault_latch_bank #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_rstn,
	input  wire logic [WIDTH-1:0] i_set,
	input  wire logic             i_clear,
	output logic      [WIDTH-1:0] o_flags
);
	import fault_irq_pkg::*;

	logic [WIDTH-1:0] flags_q;
	logic [WIDTH-1:0] flags_d;

	// A fault present in the clearing cycle sets the flag again, so no event is lost.
	always_comb begin
		flags_d = i_set | (flags_q & ~{WIDTH{i_clear}});
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign o_flags = flags_q;

	////////////////////////////////////////////////////////////////////////////////
	set_beats_clear_a : assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
		i_clear |=> (flags_q == $past(i_set)))
		else $error("Latch did not clear to the pending faults after a read.");

endmodule : fault_latch_bank

// [rtl/reg_read_mux.sv]
// Registered read-back multiplexer for the fault mask and latch registers.
`include "fault_irq_defs.svh"
module reg_read_mux (
	input  wire logic       i_sys_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_rd,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_cb_mask,
	input  wire logic [7:0] i_ov_mask,
	input  wire logic [7:0] i_mon_mask,
	input  wire logic [7:0] i_cb_latch,
	input  wire logic [7:0] i_summary,
	input  wire logic [7:0] i_ch1_latch,
	output logic      [7:0] o_rdata,
	output logic            o_rvalid
);
	import fault_irq_pkg::*;

	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       rvalid_q;
	logic       rvalid_d;

	always_comb begin
		rdata_d  = rdata_q;
		rvalid_d = i_rd;
		if (i_rd) begin
			if (i_addr == `ADDR_CLOCK_BOOST_MASK) begin
				rdata_d = i_cb_mask;
			end else if (i_addr == `ADDR_OV_MASK) begin
				rdata_d = i_ov_mask;
			end else if (i_addr == `ADDR_MON_MASK) begin
				rdata_d = i_mon_mask;
			end else if (i_addr == `ADDR_CB_LATCH) begin
				rdata_d = i_cb_latch;
			end else if (i_addr == `ADDR_SUMMARY) begin
				rdata_d = i_summary;
			end else if (i_addr == `ADDR_CH1_LATCH) begin
				rdata_d = i_ch1_latch;
			end else begin
				rdata_d = `READ_UNMAPPED;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_q  <= `READ_UNMAPPED;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign o_rdata  = rdata_q;
	assign o_rvalid = rvalid_q;

endmodule : reg_read_mux

// [rtl/fault_interrupt_mask_latch.sv]
// Interrupt masks, latched fault flags and the device interrupt for the input diagnostics.
//
// What this block does
// - Overvoltage mask bit 7 masks positive input
// - Overvoltage mask bit 6 masks negative input
// - Mask zero passes event, one suppresses
// - Monitor mask bits 7,6 mask thresholds
// - Monitor mask bits 5,4 voice activity, reset 0x30
// - Monitor mask bits 3..0 mask bias faults
// - Latch bit 7 clock error, read clears
// - Latch bit 6 PLL lock, read clears
// - Latch bits 5..3 boost faults, read clears
// - Summary bits 7,6 show channel faults
// - Summary bit 3 battery short, low battery
// - Channel 1 bits 7,6 open and shorted
// - Channel 1 bits 5,4 short to ground
// - Channel 1 bits 3,2 short to bias
// - Channel 1 bits 1,0 short to battery
// - Clock boost mask resets 0xF8, bits 7..3
`include "fault_irq_defs.svh"
module fault_interrupt_mask_latch (
	input  wire logic                              i_sys_clk,
	input  wire logic                              i_rstn,
	input  wire fault_irq_pkg::reg_req_t           i_reg_req,
	output logic                       [7:0]       o_reg_rdata,
	output logic                                   o_reg_rvalid,
	input  wire fault_irq_pkg::clock_boost_fault_t i_clock_boost_fault,
	input  wire fault_irq_pkg::ch1_fault_t         i_ch1_fault,
	input  wire logic                              i_battery_short_low_bias,
	input  wire fault_irq_pkg::neighbour_t         i_neighbour,
	output logic                       [7:0]       o_overvoltage_irq_mask,
	output logic                       [7:0]       o_monitor_bias_irq_mask,
	output logic                                   o_irq
);
	import fault_irq_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Mask registers.

	logic [7:0] clock_boost_irq_mask_q;
	logic [7:0] clock_boost_irq_mask_d;
	logic [7:0] overvoltage_irq_mask_q;
	logic [7:0] overvoltage_irq_mask_d;
	logic [7:0] monitor_bias_irq_mask_q;
	logic [7:0] monitor_bias_irq_mask_d;

	logic       wr_cb_mask;
	logic       wr_ov_mask;
	logic       wr_mon_mask;
	logic       rd_cb_latch;
	logic       rd_summary;
	logic       rd_ch1_latch;

	always_comb begin
		wr_cb_mask   = 1'b0;
		wr_ov_mask   = 1'b0;
		wr_mon_mask  = 1'b0;
		rd_cb_latch  = 1'b0;
		rd_summary   = 1'b0;
		rd_ch1_latch = 1'b0;
		if (i_reg_req.addr == `ADDR_CLOCK_BOOST_MASK) begin
			wr_cb_mask = i_reg_req.wr;
		end else if (i_reg_req.addr == `ADDR_OV_MASK) begin
			wr_ov_mask = i_reg_req.wr;
		end else if (i_reg_req.addr == `ADDR_MON_MASK) begin
			wr_mon_mask = i_reg_req.wr;
		end else if (i_reg_req.addr == `ADDR_CB_LATCH) begin
			rd_cb_latch = i_reg_req.rd;
		end else if (i_reg_req.addr == `ADDR_SUMMARY) begin
			rd_summary = i_reg_req.rd;
		end else if (i_reg_req.addr == `ADDR_CH1_LATCH) begin
			rd_ch1_latch = i_reg_req.rd;
		end
	end

	// Reserved bits are never stored, so a host that ignores the write-zero
	// convention still reads them back as zero.
	always_comb begin
		clock_boost_irq_mask_d  = clock_boost_irq_mask_q;
		overvoltage_irq_mask_d  = overvoltage_irq_mask_q;
		monitor_bias_irq_mask_d = monitor_bias_irq_mask_q;
		if (wr_cb_mask) begin
			clock_boost_irq_mask_d = i_reg_req.wdata & `WMASK_CB;
		end
		if (wr_ov_mask) begin
			overvoltage_irq_mask_d = i_reg_req.wdata & `WMASK_OV;
		end
		if (wr_mon_mask) begin
			monitor_bias_irq_mask_d = i_reg_req.wdata & `WMASK_MON;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			clock_boost_irq_mask_q  <= `RST_CB_MASK & `WMASK_CB;
			overvoltage_irq_mask_q  <= `RST_OV_MASK;
			monitor_bias_irq_mask_q <= `RST_MON_MASK;
		end else begin
			clock_boost_irq_mask_q  <= clock_boost_irq_mask_d;
			overvoltage_irq_mask_q  <= overvoltage_irq_mask_d;
			monitor_bias_irq_mask_q <= monitor_bias_irq_mask_d;
		end
	end

	assign o_overvoltage_irq_mask  = overvoltage_irq_mask_q;
	assign o_monitor_bias_irq_mask = monitor_bias_irq_mask_q;

	////////////////////////////////////////////////////////////////////////////////
	// Latched fault flags.

	logic [4:0] cb_flags;
	logic [7:0] ch1_flags;
	logic [0:0] battery_flag;
	logic [7:0] clock_boost_irq_latch;
	logic [7:0] channel_fault_summary;
	logic [7:0] channel1_input_fault_latch;

	fault_latch_bank #(
		.WIDTH (5)
	) u_cb_latch (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_set     (i_clock_boost_fault),
		.i_clear   (rd_cb_latch),
		.o_flags   (cb_flags)
	);

	fault_latch_bank #(
		.WIDTH (8)
	) u_ch1_latch (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_set     (i_ch1_fault),
		.i_clear   (rd_ch1_latch),
		.o_flags   (ch1_flags)
	);

	fault_latch_bank #(
		.WIDTH (1)
	) u_battery_latch (
		.i_sys_clk (i_sys_clk),
		.i_rstn    (i_rstn),
		.i_set     (i_battery_short_low_bias),
		.i_clear   (rd_summary),
		.o_flags   (battery_flag)
	);

	// Bits 2 to 0 of the clock and boost latch are reserved and read zero.
	always_comb begin
		clock_boost_irq_latch = `RST_LATCH;
		clock_boost_irq_latch[`CB_FIELD_HI:`CB_FIELD_LO] = cb_flags;
	end

	assign channel1_input_fault_latch = ch1_flags;

	// The channel bits mirror the per-channel latches, so they drop together
	// with them rather than needing a read of their own.
	always_comb begin
		channel_fault_summary = `RST_LATCH;
		channel_fault_summary[`SUM_CH1_BIT]  = |ch1_flags;
		channel_fault_summary[`SUM_CH2_BIT]  = i_neighbour.ch2_latched_any;
		channel_fault_summary[`SUM_VBAT_BIT] = battery_flag[0];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt output.

	logic [7:0] pend_cb;
	logic [7:0] pend_ov;
	logic [7:0] pend_mon;
	logic [7:0] pend_sum;
	logic [7:0] pend_ch1;
	logic [7:0] ov_flags;
	logic       irq_q;
	logic       irq_d;

	always_comb begin
		ov_flags = `RST_LATCH;
		ov_flags[`OV_POS_BIT] = i_neighbour.ov_latched[1];
		ov_flags[`OV_NEG_BIT] = i_neighbour.ov_latched[0];
	end

	// A channel 1 fault reaches the pin through the summary bit only when both
	// its own mask and the channel mask let it pass.
	always_comb begin
		pend_cb  = masked_pending(clock_boost_irq_latch, clock_boost_irq_mask_q);
		pend_ov  = masked_pending(ov_flags, overvoltage_irq_mask_q);
		pend_mon = masked_pending(i_neighbour.mon_latched, monitor_bias_irq_mask_q);
		pend_ch1 = masked_pending(channel1_input_fault_latch, i_neighbour.ch1_mask);
		pend_sum = masked_pending(channel_fault_summary, i_neighbour.summary_mask);
		pend_sum[`SUM_CH1_BIT] = pend_sum[`SUM_CH1_BIT] & (|pend_ch1);
		irq_d = |{pend_cb, pend_ov, pend_mon, pend_sum};
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	assign o_irq = irq_q;

	////////////////////////////////////////////////////////////////////////////////
	// Read-back.

	reg_read_mux u_read_mux (
		.i_sys_clk   (i_sys_clk),
		.i_rstn      (i_rstn),
		.i_rd        (i_reg_req.rd),
		.i_addr      (i_reg_req.addr),
		.i_cb_mask   (clock_boost_irq_mask_q),
		.i_ov_mask   (overvoltage_irq_mask_q),
		.i_mon_mask  (monitor_bias_irq_mask_q),
		.i_cb_latch  (clock_boost_irq_latch),
		.i_summary   (channel_fault_summary),
		.i_ch1_latch (channel1_input_fault_latch),
		.o_rdata     (o_reg_rdata),
		.o_rvalid    (o_reg_rvalid)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb_main @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);

	ov_pos_mask_a : assert property (
		(overvoltage_irq_mask_q[`OV_POS_BIT] && !i_neighbour.ov_latched[0]
		&& pend_cb == 8'h00 && pend_mon == 8'h00 && pend_sum == 8'h00) |=> !o_irq)
		else $error("Masked positive overvoltage still raised the interrupt.");

	ov_reserved_zero_a : assert property (
		(o_overvoltage_irq_mask[5:0] == 6'h00))
		else $error("Overvoltage mask reserved bits are not zero.");

	mask_pass_a : assert property (
		(i_neighbour.ov_latched[1] && !overvoltage_irq_mask_q[`OV_POS_BIT]) |=> o_irq)
		else $error("Unmasked overvoltage did not raise the interrupt.");

	mon_write_a : assert property (
		wr_mon_mask |=> (monitor_bias_irq_mask_q == $past(i_reg_req.wdata)))
		else $error("Monitor mask write was not stored.");

	vad_mask_a : assert property (
		(i_neighbour.mon_latched == 8'h30 && monitor_bias_irq_mask_q == 8'h30
		&& pend_cb == 8'h00 && pend_ov == 8'h00 && pend_sum == 8'h00) |=> !o_irq)
		else $error("Masked voice activity events raised the interrupt.");

	bias_pass_a : assert property (
		(i_neighbour.mon_latched[`MON_BIAS_SC_BIT]
		&& !monitor_bias_irq_mask_q[`MON_BIAS_SC_BIT]) |=> o_irq)
		else $error("Unmasked bias short did not raise the interrupt.");

	clock_err_latch_a : assert property (
		(i_clock_boost_fault.clock_error && !rd_cb_latch)
		##1 (!i_clock_boost_fault.clock_error && !rd_cb_latch)[*2]
		|-> clock_boost_irq_latch[`CB_FIELD_HI])
		else $error("Clock error flag was not held until read.");

	cb_read_clear_a : assert property (
		(rd_cb_latch && i_clock_boost_fault == 5'h00) |=> (clock_boost_irq_latch == 8'h00))
		else $error("Clock and boost latch did not clear on read.");

	cb_read_value_a : assert property (
		rd_cb_latch |=> (o_reg_rvalid && o_reg_rdata == $past(clock_boost_irq_latch)))
		else $error("Clock and boost latch read returned the wrong value.");

	sum_ch1_a : assert property (
		(i_ch1_fault != 8'h00) |=> channel_fault_summary[`SUM_CH1_BIT])
		else $error("Channel 1 fault not shown in the summary.");

	battery_sum_a : assert property (
		(i_battery_short_low_bias && !rd_summary) |=> channel_fault_summary[`SUM_VBAT_BIT]
		##1 channel_fault_summary[`SUM_VBAT_BIT] || $past(rd_summary))
		else $error("Battery short summary flag did not latch.");

	ch1_latch_a : assert property (
		(!rd_ch1_latch) |=> ((channel1_input_fault_latch & $past(i_ch1_fault))
		== $past(i_ch1_fault)))
		else $error("Channel 1 input fault was not latched.");

	ch1_refire_a : assert property (
		(rd_ch1_latch && i_ch1_fault.open_input) |=> channel1_input_fault_latch[7])
		else $error("Persistent open input was lost by the read.");

	cb_mask_reset_a : assert property (
		$rose(i_rstn) |-> (clock_boost_irq_mask_q == 8'hF8))
		else $error("Clock and boost mask reset value is wrong.");

	irq_follow_a : assert property (
		(irq_d != o_irq) |=> (o_irq == $past(irq_d)))
		else $error("Interrupt output did not follow the pending flags.");

	irq_clear_a : assert property (
		(pend_cb == 8'h00 && pend_ov == 8'h00 && pend_mon == 8'h00
		&& pend_sum == 8'h00) |=> !o_irq)
		else $error("Interrupt stayed high with nothing pending.");

endmodule : fault_interrupt_mask_latch

// [tb/host_model.sv]
// Host software model that issues register reads and writes over the strobe bus.
`include "fault_irq_defs.svh"
module host_model
	import fault_irq_pkg::*;
(
	input  wire logic                    i_sys_clk,
	input  wire logic [7:0]              i_rdata,
	input  wire logic                    i_rvalid,
	output fault_irq_pkg::reg_req_t      o_req
);
	timeunit 1ns;
	timeprecision 100ps;

	initial o_req = '0;

	// Software only ever writes zero into reserved positions, so it trims each write itself.
	function automatic logic [7:0] writable(input logic [7:0] a);
		case (a)
			`ADDR_CLOCK_BOOST_MASK: return `WMASK_CB;
			`ADDR_OV_MASK:          return `WMASK_OV;
			default:                return 8'hFF;
		endcase
	endfunction : writable

	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		#1;
		o_req.wr    = 1'b1;
		o_req.addr  = a;
		o_req.wdata = d & writable(a);
		@(posedge i_sys_clk);
		#1;
		o_req.wr    = 1'b0;
	endtask : reg_write

	// The answer is taken 1 ns after the read edge, while the valid pulse stands.
	task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge i_sys_clk);
		#1;
		o_req.rd   = 1'b1;
		o_req.addr = a;
		@(posedge i_sys_clk);
		#1;
		o_req.rd   = 1'b0;
		d = i_rdata;
		v = i_rvalid;
	endtask : reg_read

endmodule : host_model

// [tb/tb_fault_interrupt_mask_latch.sv]
// Self-checking bench comparing the fault latch block with a behavioural model.
`include "fault_irq_defs.svh"
module tb_fault_interrupt_mask_latch;
	timeunit 1ns;
	timeprecision 100ps;
	import fault_irq_pkg::*;

	logic               i_sys_clk = 1'b0;
	logic               i_rstn    = 1'b0;
	reg_req_t           req;
	logic [7:0]         rdata;
	logic               rvalid;
	clock_boost_fault_t cbf       = '0;
	ch1_fault_t         ch1f      = '0;
	logic               vbat      = 1'b0;
	neighbour_t         nb        = '0;
	logic [7:0]         ovm_o;
	logic [7:0]         monm_o;
	logic               irq;
	int                 num_errors = 0;
	int                 checked    = 0;
	logic [31:0]        seed       = 32'h0000B663;
	logic [7:0]         m_cbm      = 8'hF8;
	logic [7:0]         m_ovm      = 8'h00;
	logic [7:0]         m_monm     = 8'h30;
	logic [7:0]         m_cb       = 8'h00;
	logic [7:0]         m_ch1      = 8'h00;
	logic               m_vbat     = 1'b0;
	logic [7:0]         addrs [7]  = '{8'h2F, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h41};

	always #2 i_sys_clk = ~i_sys_clk;

	fault_interrupt_mask_latch i_fault_interrupt_mask_latch (
		.i_sys_clk               (i_sys_clk),
		.i_rstn                  (i_rstn),
		.i_reg_req               (req),
		.o_reg_rdata             (rdata),
		.o_reg_rvalid            (rvalid),
		.i_clock_boost_fault     (cbf),
		.i_ch1_fault             (ch1f),
		.i_battery_short_low_bias(vbat),
		.i_neighbour             (nb),
		.o_overvoltage_irq_mask  (ovm_o),
		.o_monitor_bias_irq_mask (monm_o),
		.o_irq                   (irq)
	);

	host_model i_host_model (
		.i_sys_clk(i_sys_clk),
		.i_rdata  (rdata),
		.i_rvalid (rvalid),
		.o_req    (req)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	function automatic logic [7:0] model_reg(input logic [7:0] a);
		case (a)
			`ADDR_CLOCK_BOOST_MASK: return m_cbm;
			`ADDR_OV_MASK:          return m_ovm;
			`ADDR_MON_MASK:         return m_monm;
			`ADDR_CB_LATCH:         return m_cb;
			`ADDR_SUMMARY:          return {m_ch1 != 8'h00, nb.ch2_latched_any, 2'b00, m_vbat, 3'b000};
			`ADDR_CH1_LATCH:        return m_ch1;
			default:                return 8'h00;
		endcase
	endfunction : model_reg

	// A read clears the flags, but any fault still present at the read edge sets them again.
	task automatic do_read(input logic [7:0] a);
		logic [7:0] d;
		logic       v;
		logic [7:0] exp;
		exp = model_reg(a);
		i_host_model.reg_read(a, d, v);
		check("rvalid", {7'h00, v}, 8'h01);
		check("rdata", d, exp);
		if (a == `ADDR_CB_LATCH) m_cb = {cbf, 3'b000};
		if (a == `ADDR_SUMMARY) m_vbat = vbat;
		if (a == `ADDR_CH1_LATCH) m_ch1 = ch1f;
	endtask : do_read

	task automatic do_write(input logic [7:0] a, input logic [7:0] d);
		i_host_model.reg_write(a, d);
		if (a == `ADDR_CLOCK_BOOST_MASK) m_cbm = d & 8'hF8;
		if (a == `ADDR_OV_MASK) m_ovm = d & 8'hC0;
		if (a == `ADDR_MON_MASK) m_monm = d;
	endtask : do_write

	task automatic pulse(input logic [4:0] c, input logic [7:0] h, input logic b);
		@(posedge i_sys_clk);
		#1;
		cbf  = c;
		ch1f = h;
		vbat = b;
		@(posedge i_sys_clk);
		#1;
		cbf  = '0;
		ch1f = '0;
		vbat = 1'b0;
		m_cb   = m_cb | {c, 3'b000};
		m_ch1  = m_ch1 | h;
		m_vbat = m_vbat | b;
	endtask : pulse

	function automatic logic irq_exp();
		logic [7:0] sm;
		sm = nb.summary_mask;
		return ((m_cb & ~m_cbm) != 8'h00) || ((nb.ov_latched & ~m_ovm[7:6]) != 2'b00)
			|| ((nb.mon_latched & ~m_monm) != 8'h00)
			|| (!sm[7] && ((m_ch1 & ~nb.ch1_mask) != 8'h00))
			|| (nb.ch2_latched_any && !sm[6]) || (m_vbat && !sm[3]);
	endfunction : irq_exp

	task automatic settle();
		repeat (3) @(posedge i_sys_clk);
		#1;
		check("irq", {7'h00, irq}, {7'h00, irq_exp()});
		check("ov_mask_port", ovm_o, m_ovm);
		check("mon_mask_port", monm_o, m_monm);
	endtask : settle

	task automatic tally_and_finish();
		if (num_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : tally_and_finish

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] r;
		repeat (5) @(posedge i_sys_clk);
		#1;
		i_rstn = 1'b1;
		foreach (addrs[k]) do_read(addrs[k]);
		settle();
		// Voice activity events stay off the pin while the reset mask holds them back.
		nb.mon_latched = 8'h30;
		settle();
		nb = '0;
		// A fault held across the read edge must survive the read.
		@(posedge i_sys_clk);
		#1;
		ch1f = 8'h81;
		m_ch1 = 8'h81;
		do_read(`ADDR_CH1_LATCH);
		@(posedge i_sys_clk);
		#1;
		ch1f = 8'h00;
		do_read(`ADDR_CH1_LATCH);
		do_read(`ADDR_CH1_LATCH);
		for (int n = 0; n < 400; n++) begin
			r = xs();
			case (r[2:0])
				3'd0, 3'd1: do_write(addrs[r[5:3] % 7], r[15:8]);
				3'd2, 3'd3: pulse(r[12:8] & r[20:16], r[23:16] & r[31:24], r[24] & r[25]);
				3'd4: nb = neighbour_t'(27'(r & xs()));
				default: do_read(addrs[r[5:3] % 7]);
			endcase
			settle();
		end
		tally_and_finish();
	end

	initial begin
		#100000;
		num_errors++;
		tally_and_finish();
	end

endmodule : tb_fault_interrupt_mask_latch
